// ### hdl/nicm_pkg.sv
// package for the interrupt cause / mask block: widths, reset values,
// bit positions, timing constants and the carrier types.
// assumes one clock (mclk_i, 250 MHz) and a synchronous active-high reset.
//
// Notes on behaviour
// - a cause read returns every pending bit and clears only the bits it returned.
// - each one written to the cause set port sets the matching cause bit.
// - a hardware event in the same cycle as a clearing read leaves its bit set.
// - cause set writes always land; hardware and software sets are ORed together.
// - the interrupt is asserted only while some cause bit and its mask bit are both one.
// - events are recorded in the cause register whatever the mask holds.
// - each one written to the mask set port sets that mask bit, others unchanged.
// - each one written to the mask clear port clears that mask bit, others unchanged.
// - reading through the mask set port returns the mask with no side effect.
// - four ports exist: cause read, cause set, mask set/read and mask clear.
// - all sources land in one cause register so one read gives the whole state.
// - a programmable minimum interval throttles how often interrupts are signalled.
// - receive packets may accumulate, by count or by delay, before a receive event.
// - pending unmasked interrupts may be signalled as a message instead of the wire.

package nicm_pkg;

	// register widths and reset values
	localparam int              CAUSE_W    = 32;
	localparam logic [31:0]     CAUSE_RST  = 32'h0000_0000;
	localparam logic [31:0]     MASK_RST   = 32'h0000_0000;

	// receive timer cause bit, driven by the coalescer
	localparam int              CAUSE_RXT_BIT = 7;

	// throttle and coalescing field widths
	localparam int              ITR_W      = 16;
	localparam int              PKT_CNT_W  = 8;
	localparam int              RX_DLY_W   = 16;

	// time base: throttle and delay intervals count in 256 ns units
	localparam int              CLK_PERIOD_NS = 4;
	localparam int              TICK_NS       = 256;
	localparam int              TICK_CYC      = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int              TICK_CNT_W    = 8;

	// one write strobe with its data
	typedef struct packed {
		logic               vld;
		logic [CAUSE_W-1:0] data;
	} nicm_wr_s;

	// one read answer with its data
	typedef struct packed {
		logic               vld;
		logic [CAUSE_W-1:0] data;
	} nicm_rd_s;

	// signalling state
	typedef enum logic [1:0] {
		NICM_IDLE   = 2'b01,
		NICM_ACTIVE = 2'b10
	} nicm_sig_e;

endpackage

// ### hdl/nicm_throttle.sv
// interrupt rate throttle: after each signalled interrupt, holds the
// gate shut for a programmed number of 256 ns ticks.
// assumes tick_i is a one-cycle enable from the shared divider.
`timescale 1ns/10ps

module nicm_throttle (
	input  wire logic                       mclk_i,
	input  wire logic                       srst_i,
	input  wire logic                       tick_i,
	input  wire logic [nicm_pkg::ITR_W-1:0] interval_i,
	input  wire logic                       fire_i,
	output logic                            open_o
);

	logic [nicm_pkg::ITR_W-1:0] hold_r;

	////////////////////////////////////////////////////////////////////////
	// reload on each fire, count down on ticks; zero interval never shuts
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			hold_r <= '0;
		end else if (fire_i) begin
			hold_r <= interval_i;
		end else if (tick_i && hold_r != '0) begin
			hold_r <= hold_r - 1'b1;
		end
	end

	// gate may be up to one tick early: tick phase is free running
	assign open_o = (hold_r == '0);

endmodule

// ### hdl/nicm_rx_coalesce.sv
// receive coalescing: turns packet pulses into one receive event once
// a packet count is reached or a delay after the first packet runs out.
// assumes tick_i is a one-cycle enable from the shared divider.
`timescale 1ns/10ps

module nicm_rx_coalesce (
	input  wire logic                           mclk_i,
	input  wire logic                           srst_i,
	input  wire logic                           tick_i,
	input  wire logic                           pkt_i,
	input  wire logic [nicm_pkg::PKT_CNT_W-1:0] thresh_i,
	input  wire logic [nicm_pkg::RX_DLY_W-1:0]  delay_i,
	output logic                                event_o
);

	logic [nicm_pkg::PKT_CNT_W-1:0] cnt_r;
	logic [nicm_pkg::PKT_CNT_W-1:0] cnt_nxt;
	logic [nicm_pkg::RX_DLY_W-1:0]  timer_r;
	logic                           timeout;
	logic                           fire;

	////////////////////////////////////////////////////////////////////////
	// saturating packet count; timeout on the tick that empties the timer
	always_comb begin
		cnt_nxt = cnt_r;
		if (pkt_i && cnt_r != '1) begin
			cnt_nxt = cnt_r + 1'b1;
		end
		timeout = (cnt_r != '0) && tick_i && (timer_r == {{(nicm_pkg::RX_DLY_W-1){1'b0}}, 1'b1});
		fire    = (cnt_nxt != '0) && ((cnt_nxt >= thresh_i) || (delay_i == '0) || timeout);
	end

	// batch state; a packet arriving with the fire belongs to that batch
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			cnt_r   <= '0;
			timer_r <= '0;
			event_o <= 1'b0;
		end else begin
			event_o <= fire;
			if (fire) begin
				cnt_r   <= '0;
				timer_r <= '0;
			end else begin
				cnt_r <= cnt_nxt;
				if (pkt_i && cnt_r == '0) begin
					timer_r <= delay_i;
				end else if (tick_i && timer_r != '0) begin
					timer_r <= timer_r - 1'b1;
				end
			end
		end
	end

endmodule

// ### hdl/nicm_intr_ctrl.sv
// interrupt cause and mask block: cause register with clear-on-read and
// set port, mask with set and clear ports, throttled wire or message out.
// assumes all inputs synchronous to mclk_i; strobes are one-cycle pulses.
`timescale 1ns/10ps

module nicm_intr_ctrl (
	input  wire logic                                mclk_i,
	input  wire logic                                srst_i,
	// hardware event pulses, one per cause bit
	input  wire logic [nicm_pkg::CAUSE_W-1:0]        hw_event_i,
	input  wire logic                                rx_pkt_i,
	// cause read port
	input  wire logic                                cause_rd_i,
	output nicm_pkg::nicm_rd_s                       cause_rd_o,
	// cause set port
	input  nicm_pkg::nicm_wr_s                       cause_set_i,
	// mask set / read port
	input  nicm_pkg::nicm_wr_s                       mask_set_i,
	input  wire logic                                mask_rd_i,
	output nicm_pkg::nicm_rd_s                       mask_rd_o,
	// mask clear port
	input  nicm_pkg::nicm_wr_s                       mask_clr_i,
	// configuration levels
	input  wire logic [nicm_pkg::ITR_W-1:0]          itr_interval_i,
	input  wire logic [nicm_pkg::PKT_CNT_W-1:0]      rx_pkt_thresh_i,
	input  wire logic [nicm_pkg::RX_DLY_W-1:0]       rx_delay_i,
	input  wire logic                                msi_en_i,
	// open-drain interrupt wire and message request
	output logic                                     irq_wire_o,
	output logic                                     irq_wire_oe_n_o,
	output logic                                     msi_req_o,
	output logic                                     irq_pending_o
);

	////////////////////////////////////////////////////////////////////////
	// declarations

	logic [nicm_pkg::CAUSE_W-1:0]    cause_r;
	logic [nicm_pkg::CAUSE_W-1:0]    cause_nxt;
	logic [nicm_pkg::CAUSE_W-1:0]    mask_r;
	logic [nicm_pkg::CAUSE_W-1:0]    mask_nxt;
	logic [nicm_pkg::CAUSE_W-1:0]    event_all;
	logic [nicm_pkg::CAUSE_W-1:0]    rx_event_vec;
	logic                            rx_event;
	logic                            pending_nxt;
	logic                            gate_open;
	logic                            fire;
	logic                            tick;
	logic [nicm_pkg::TICK_CNT_W-1:0] tick_cnt_r;
	nicm_pkg::nicm_sig_e             sig_r;
	nicm_pkg::nicm_sig_e             sig_nxt;

	////////////////////////////////////////////////////////////////////////
	// time base: one-cycle tick every 256 ns shared by throttle and delay

	localparam logic [nicm_pkg::TICK_CNT_W-1:0] TICK_LAST =
		nicm_pkg::TICK_CNT_W'(nicm_pkg::TICK_CYC - 1);

	// free-running divider, so intervals are accurate to one tick
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			tick_cnt_r <= '0;
		end else if (tick_cnt_r == TICK_LAST) begin
			tick_cnt_r <= '0;
		end else begin
			tick_cnt_r <= tick_cnt_r + 1'b1;
		end
	end

	assign tick = (tick_cnt_r == TICK_LAST);

	////////////////////////////////////////////////////////////////////////
	// receive coalescing feeds the receive timer cause bit

	nicm_rx_coalesce i_nicm_rx_coalesce (
		.mclk_i   (mclk_i),
		.srst_i   (srst_i),
		.tick_i   (tick),
		.pkt_i    (rx_pkt_i),
		.thresh_i (rx_pkt_thresh_i),
		.delay_i  (rx_delay_i),
		.event_o  (rx_event)
	);

	// coalesced event replaces nothing: it is ORed onto its cause bit
	always_comb begin
		rx_event_vec                          = '0;
		rx_event_vec[nicm_pkg::CAUSE_RXT_BIT] = rx_event;
	end

	// every source gathered into the one cause vector
	assign event_all = hw_event_i | rx_event_vec;

	////////////////////////////////////////////////////////////////////////
	// cause register next value
	// a read clears only what it returned; sets of the same cycle win
	always_comb begin
		cause_nxt = cause_r;
		if (cause_rd_i) begin
			cause_nxt = '0;
		end
		cause_nxt = cause_nxt | event_all;
		if (cause_set_i.vld) begin
			cause_nxt = cause_nxt | cause_set_i.data;
		end
	end

	// cause storage, cleared at reset
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			cause_r <= nicm_pkg::CAUSE_RST;
		end else begin
			cause_r <= cause_nxt;
		end
	end

	// cause read answer: the value held at the read, one cycle later
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			cause_rd_o <= '0;
		end else begin
			cause_rd_o.vld <= cause_rd_i;
			if (cause_rd_i) begin
				cause_rd_o.data <= cause_r;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// mask register
	// set then clear: a bit named in both ports in one cycle ends cleared
	always_comb begin
		mask_nxt = mask_r;
		if (mask_set_i.vld) begin
			mask_nxt = mask_nxt | mask_set_i.data;
		end
		if (mask_clr_i.vld) begin
			mask_nxt = mask_nxt & ~mask_clr_i.data;
		end
	end

	// mask storage, all sources blocked after reset
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			mask_r <= nicm_pkg::MASK_RST;
		end else begin
			mask_r <= mask_nxt;
		end
	end

	// mask read through the set port: plain copy, no side effect
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			mask_rd_o <= '0;
		end else begin
			mask_rd_o.vld <= mask_rd_i;
			if (mask_rd_i) begin
				mask_rd_o.data <= mask_r;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pending term from next values, so the output flop drops on the
	// same edge as the clearing read or mask clear
	assign pending_nxt = |(cause_nxt & mask_nxt);

	nicm_throttle i_nicm_throttle (
		.mclk_i     (mclk_i),
		.srst_i     (srst_i),
		.tick_i     (tick),
		.interval_i (itr_interval_i),
		.fire_i     (fire),
		.open_o     (gate_open)
	);

	////////////////////////////////////////////////////////////////////////
	// signalling state: idle until pending and throttle open, active
	// while pending stays; the throttle restarts at each new assertion
	always_comb begin
		sig_nxt = sig_r;
		fire    = 1'b0;
		unique case (sig_r)
			nicm_pkg::NICM_IDLE: begin
				if (pending_nxt && gate_open) begin
					sig_nxt = nicm_pkg::NICM_ACTIVE;
					fire    = 1'b1;
				end
			end
			nicm_pkg::NICM_ACTIVE: begin
				if (!pending_nxt) begin
					sig_nxt = nicm_pkg::NICM_IDLE;
				end
			end
			default: begin
				sig_nxt = nicm_pkg::NICM_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			sig_r <= nicm_pkg::NICM_IDLE;
		end else begin
			sig_r <= sig_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs, each straight from a flop
	// the wire is pulled low only; the pin's level is resolved outside
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			irq_wire_o      <= 1'b0;
			irq_wire_oe_n_o <= 1'b1;
			msi_req_o       <= 1'b0;
			irq_pending_o   <= 1'b0;
		end else begin
			irq_wire_o      <= 1'b0;
			// wire mode: drive low while active and message mode off
			irq_wire_oe_n_o <= !((sig_nxt == nicm_pkg::NICM_ACTIVE) && !msi_en_i);
			// message mode: one request per new assertion
			msi_req_o       <= fire && msi_en_i;
			irq_pending_o   <= pending_nxt;
		end
	end

endmodule

// ### sim/nicm_host_line.sv
// host side of the interrupt line: an open-drain wire with a pull-up.
// assumes the design pulls low only while its enable is low.
`timescale 1ns/10ps

module nicm_host_line (
	input  wire logic irq_wire_i,
	input  wire logic irq_wire_oe_n_i,
	output logic      irq_line_o
);
	// released wire floats to the pull-up, never to the last driven value
	assign irq_line_o = irq_wire_oe_n_i ? 1'b1 : irq_wire_i;
endmodule

// ### sim/nicm_intr_monitor.sv
// checker for the interrupt cause / mask block.
// assumes binding onto nicm_intr_ctrl; one clock, sync reset.
`timescale 1ns/10ps

module nicm_intr_monitor (
	input  wire logic                         mclk_i,
	input  wire logic                         srst_i,
	input  wire logic [nicm_pkg::CAUSE_W-1:0] hw_event_i,
	input  wire logic                         cause_rd_i,
	input  nicm_pkg::nicm_rd_s                cause_rd_o,
	input  nicm_pkg::nicm_wr_s                cause_set_i,
	input  wire logic                         msi_en_i,
	input  wire logic                         irq_wire_oe_n_o,
	input  wire logic                         msi_req_o,
	input  wire logic                         irq_pending_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (srst_i);
	////////////////////////////////////////
	// set then read: the read answer must carry the set bits
	sequence s_hw_rd;
		(hw_event_i != 32'h0) ##1 cause_rd_i;
	endsequence
	sequence s_sw_rd;
		cause_set_i.vld ##1 cause_rd_i;
	endsequence
	sequence s_race_rd;
		(hw_event_i != 32'h0) && cause_rd_i ##1 cause_rd_i;
	endsequence
	a_hw_recorded: assert property (s_hw_rd |=> cause_rd_o.vld && (cause_rd_o.data & $past(hw_event_i, 2)) == $past(hw_event_i, 2))
		else $error("hardware event missing from cause read");
	a_sw_recorded: assert property (s_sw_rd |=> (cause_rd_o.data & $past(cause_set_i.data, 2)) == $past(cause_set_i.data, 2))
		else $error("software set missing from cause read");
	a_race_kept: assert property (s_race_rd |=> (cause_rd_o.data & $past(hw_event_i, 2)) == $past(hw_event_i, 2))
		else $error("event lost against clearing read");
	a_reset_quiet: assert property ($fell(srst_i) |-> irq_wire_oe_n_o && !irq_pending_o && !cause_rd_o.vld)
		else $error("outputs not quiet after reset");
	a_wire_pending: assert property (!irq_pending_o |-> irq_wire_oe_n_o)
		else $error("wire pulled without a pending cause");
	a_read_release: assert property (irq_pending_o && cause_rd_i && hw_event_i == 32'h0 && !cause_set_i.vld |=> irq_wire_oe_n_o && !irq_pending_o)
		else $error("wire not released after clearing read");
	a_msi_pulse: assert property (msi_req_o |-> irq_pending_o ##1 !msi_req_o)
		else $error("message request not a single pending pulse");
	a_msi_release: assert property (msi_en_i && $past(msi_en_i) |-> irq_wire_oe_n_o)
		else $error("wire pulled in message mode");
endmodule

bind nicm_intr_ctrl nicm_intr_monitor i_nicm_intr_monitor (.mclk_i(mclk_i), .srst_i(srst_i),
	.hw_event_i(hw_event_i), .cause_rd_i(cause_rd_i), .cause_rd_o(cause_rd_o), .cause_set_i(cause_set_i),
	.msi_en_i(msi_en_i), .irq_wire_oe_n_o(irq_wire_oe_n_o), .msi_req_o(msi_req_o), .irq_pending_o(irq_pending_o));

// ### sim/tb_nicm_intr_ctrl.sv
// testbench for the interrupt cause / mask block.
// assumes the host line model beside it; inputs driven on falling edges.
`timescale 1ns/10ps

module tb_nicm_intr_ctrl;
	logic               mclk_i = 1'b0;
	logic               srst_i = 1'b1;
	logic [31:0]        hw_event_i = 32'h0;
	logic               rx_pkt_i = 1'b0;
	logic               cause_rd_i = 1'b0;
	logic               mask_rd_i = 1'b0;
	logic               msi_en_i = 1'b0;
	nicm_pkg::nicm_wr_s cause_set_i = '0;
	nicm_pkg::nicm_wr_s mask_set_i = '0;
	nicm_pkg::nicm_wr_s mask_clr_i = '0;
	nicm_pkg::nicm_rd_s cause_rd_o;
	nicm_pkg::nicm_rd_s mask_rd_o;
	logic [15:0]        itr_interval_i = 16'h0;
	logic [15:0]        rx_delay_i = 16'hFFFF;
	logic [7:0]         rx_pkt_thresh_i = 8'h0;
	logic               irq_wire_o, irq_wire_oe_n_o, msi_req_o, irq_pending_o, irq_line;
	logic [31:0]        got;
	int                 bad_count = 0;
	int                 n_tests = 0;
	int                 n;

	nicm_intr_ctrl i_nicm_intr_ctrl (.mclk_i(mclk_i), .srst_i(srst_i), .hw_event_i(hw_event_i),
		.rx_pkt_i(rx_pkt_i), .cause_rd_i(cause_rd_i), .cause_rd_o(cause_rd_o), .cause_set_i(cause_set_i),
		.mask_set_i(mask_set_i), .mask_rd_i(mask_rd_i), .mask_rd_o(mask_rd_o), .mask_clr_i(mask_clr_i),
		.itr_interval_i(itr_interval_i), .rx_pkt_thresh_i(rx_pkt_thresh_i), .rx_delay_i(rx_delay_i),
		.msi_en_i(msi_en_i), .irq_wire_o(irq_wire_o), .irq_wire_oe_n_o(irq_wire_oe_n_o),
		.msi_req_o(msi_req_o), .irq_pending_o(irq_pending_o));
	nicm_host_line i_nicm_host_line (.irq_wire_i(irq_wire_o), .irq_wire_oe_n_i(irq_wire_oe_n_o),
		.irq_line_o(irq_line));

	// 250 MHz clock
	always #2 mclk_i = ~mclk_i;
	////////////////////////////////////////
	// shared helpers, all entered on a falling edge
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic rd(input bit m, output logic [31:0] d);
		if (m) mask_rd_i = 1'b1; else cause_rd_i = 1'b1;
		@(negedge mclk_i);
		mask_rd_i = 1'b0;
		cause_rd_i = 1'b0;
		chk("read valid", 32'h1, {31'h0, m ? mask_rd_o.vld : cause_rd_o.vld});
		d = m ? mask_rd_o.data : cause_rd_o.data;
	endtask
	// one write cycle on the three write ports; zero data means no write
	task automatic put(input logic [31:0] cs, input logic [31:0] ms, input logic [31:0] mc);
		cause_set_i = '{cs != 32'h0, cs};
		mask_set_i = '{ms != 32'h0, ms};
		mask_clr_i = '{mc != 32'h0, mc};
		@(negedge mclk_i);
		cause_set_i = '0;
		mask_set_i = '0;
		mask_clr_i = '0;
	endtask
	task automatic ev(input logic [31:0] e);
		hw_event_i = e;
		@(negedge mclk_i);
		hw_event_i = 32'h0;
	endtask
	////////////////////////////////////////
	task automatic t_reset;
		chk("line after reset", 32'h1, {31'h0, irq_line});
		rd(1'b0, got);
		chk("cause after reset", 32'h0, got);
		rd(1'b1, got);
		chk("mask after reset", 32'h0, got);
		$display("test t_reset done");
	endtask
	task automatic t_set_read;
		put(32'hA5A5_0F0F, 32'h0, 32'h0);
		chk("masked line", 32'h1, {31'h0, irq_line});
		rd(1'b0, got);
		chk("posted cause", 32'hA5A5_0F0F, got);
		rd(1'b0, got);
		chk("cleared cause", 32'h0, got);
		$display("test t_set_read done");
	endtask
	// event, software set and clearing read land in the same cycle
	task automatic t_race;
		put(32'h0000_0018, 32'h0, 32'h0);
		hw_event_i = 32'h0000_0408;
		cause_set_i = '{1'b1, 32'h0000_0200};
		rd(1'b0, got);
		hw_event_i = 32'h0;
		cause_set_i = '0;
		chk("race read", 32'h0000_0018, got);
		rd(1'b0, got);
		chk("race kept", 32'h0000_0608, got);
		rd(1'b0, got);
		$display("test t_race done");
	endtask
	task automatic t_mask;
		put(32'h0, 32'h0000_007F, 32'h0);
		put(32'h0, 32'h0, 32'h0000_000F);
		rd(1'b1, got);
		chk("mask after clear", 32'h0000_0070, got);
		put(32'h0, 32'h0000_0101, 32'h0000_0100);
		rd(1'b1, got);
		chk("mask after set", 32'h0000_0071, got);
		rd(1'b1, got);
		chk("mask reread", 32'h0000_0071, got);
		ev(32'h0000_0002);
		chk("masked event line", 32'h1, {31'h0, irq_line});
		ev(32'h0000_0020);
		chk("unmasked event line", 32'h0, {31'h0, irq_line});
		chk("pending status set", 32'h1, {31'h0, irq_pending_o});
		rd(1'b0, got);
		chk("both events kept", 32'h0000_0022, got);
		chk("line released", 32'h1, {31'h0, irq_line});
		chk("pending status clear", 32'h0, {31'h0, irq_pending_o});
		$display("test t_mask done");
	endtask
	task automatic t_msi;
		msi_en_i = 1'b1;
		ev(32'h0000_0010);
		chk("message pulse", 32'h1, {31'h0, msi_req_o});
		chk("line in message mode", 32'h1, {31'h0, irq_line});
		@(negedge mclk_i);
		chk("message pulse end", 32'h0, {31'h0, msi_req_o});
		rd(1'b0, got);
		msi_en_i = 1'b0;
		$display("test t_msi done");
	endtask
	// three packets per event; delay long enough never to expire here
	task automatic t_coalesce;
		rx_pkt_thresh_i = 8'h03;
		for (n = 0; n < 3; n++) begin
			if (n == 2) begin
				rd(1'b0, got);
				chk("early receive bit", 32'h0, got & 32'h0000_0080);
			end
			rx_pkt_i = 1'b1;
			@(negedge mclk_i);
			rx_pkt_i = 1'b0;
			@(negedge mclk_i);
		end
		@(negedge mclk_i);
		rd(1'b0, got);
		chk("batch receive bit", 32'h0000_0080, got & 32'h0000_0080);
		$display("test t_coalesce done");
	endtask
	// interval of 2 ticks of 64 cycles shuts the gate after one assertion
	task automatic t_throttle;
		itr_interval_i = 16'h0002;
		repeat (3) @(negedge mclk_i);
		ev(32'h0000_0020);
		rd(1'b0, got);
		ev(32'h0000_0020);
		n = 0;
		while (irq_wire_oe_n_o !== 1'b0 && n < 400) begin
			@(negedge mclk_i);
			n++;
		end
		chk("throttle wait", 32'h1, {31'h0, n > 55 && n < 130});
		rd(1'b0, got);
		itr_interval_i = 16'h0;
		$display("test t_throttle done");
	endtask
	////////////////////////////////////////
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (4) @(negedge mclk_i);
		srst_i = 1'b0;
		@(negedge mclk_i);
		t_reset;
		t_set_read;
		t_race;
		t_mask;
		t_msi;
		t_coalesce;
		t_throttle;
		test_done;
	end
	// the whole run takes under 1000 cycles
	initial begin
		#20000;
		bad_count++;
		$display("watchdog expired");
		test_done;
	end
endmodule
